// [common/uart_consts.svh]
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
`define CLK_HZ        100000000
`define BAUD_DEF      9600
`define BAUD_BUS      19200
`define DIV_DEF       (`CLK_HZ / (16 * `BAUD_DEF))
`define DIV_BUS       (`CLK_HZ / (16 * `BAUD_BUS))
`define A_CFG         8'h00
`define A_DIV         8'h04
`define A_TXD         8'h08
`define A_RXD         8'h0C
`define A_STAT        8'h10
`define CFG_RST       6'h01
`define B_DATA8       0
`define B_PAR_LO      1
`define B_PAR_HI      2
`define B_HWFLOW      4
`define B_EN          5
`define CH_XON        8'h11
`define CH_XOFF       8'h13
`define CH_CR         8'h0D
`define CH_LF         8'h0A
`define BRK_TICKS     8'd160
`define BRK_TICKS_PAR 8'd176
`endif

// [common/uart_pkg.sv]
package uart_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA  = 5'b00100,
    ST_PAR   = 5'b01000,
    ST_STOP  = 5'b10000
  } frame_st_t;
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_EVEN = 2'b01,
    PAR_ODD  = 2'b10
  } par_mode_t;
endpackage

// [hdl/rs232_uart_flow_control.sv]
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "uart_consts.svh"
module rs232_uart_flow_control
  import uart_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        gpib_mode,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             reset_req,
  output logic             term_seen
);
  logic [5:0]  cfg_r;
  logic [15:0] div_r;
  logic [15:0] tcnt_r;
  logic        tick;
  logic [2:0]  s1_r, s2_r, s3_r, flt_r;
  logic        rxf, hw, sw, en, data8, pen, podd;
  logic        hw_clear_r, pause_r;
  logic [7:0]  txq_r;
  logic        txq_v_r, xon_pend_r, xoff_pend_r;
  frame_st_t   tx_st_r, rx_st_r;
  logic [3:0]  tx_ph_r, rx_ph_r;
  logic [2:0]  tx_bit_r, rx_bit_r;
  logic [7:0]  tx_sh_r, rx_sh_r, rx_dat_r;
  logic        tx_par_r, rx_par_r, txd_r;
  logic        tx_go, tx_flow, tx_end, rx_end, rx_done;
  logic        rx_full_r, rx_take;
  logic        perr_r, ferr_r, brk_r, term_r;
  logic        perr_evt, ferr_evt;
  logic [7:0]  brk_cnt_r, brk_lim;
  logic [2:0]  nb;

  assign en    = cfg_r[`B_EN];
  assign hw    = cfg_r[`B_HWFLOW];
  assign sw    = !hw;
  assign data8 = cfg_r[`B_DATA8];
  assign pen   = cfg_r[`B_PAR_HI:`B_PAR_LO] != PAR_NONE;
  assign podd  = cfg_r[`B_PAR_HI:`B_PAR_LO] == PAR_ODD;
  assign nb    = data8 ? 3'd7 : 3'd6;
  assign rxf   = flt_r[0];

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_r <= `CFG_RST;
      div_r <= gpib_mode ? 16'(`DIV_BUS) : 16'(`DIV_DEF);
    end
    else if (wr && addr == `A_CFG)
    begin
      cfg_r <= wdata[5:0];
    end
    else if (wr && addr == `A_DIV && wdata[15:0] != 16'h0000)
    begin
      div_r <= wdata[15:0];
    end
  end

  assign rx_take = rd && addr == `A_RXD;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (addr)
        `A_CFG:  rdata <= {26'h000_0000, cfg_r};
        `A_DIV:  rdata <= {16'h0000, div_r};
        `A_RXD:  rdata <= {24'h00_0000, rx_dat_r};
        `A_STAT: rdata <= {24'h00_0000, pause_r, hw_clear_r, term_r,
                           brk_r, ferr_r, perr_r, txq_v_r, rx_full_r};
        default: rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

  // Sticky status: a new event in the clearing cycle keeps its bit.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      {term_r, brk_r, ferr_r, perr_r} <= 4'h0;
    else
    begin
      if (perr_evt)
        perr_r <= 1'b1;
      else if (wr && addr == `A_STAT && wdata[2])
        perr_r <= 1'b0;
      if (ferr_evt)
        ferr_r <= 1'b1;
      else if (wr && addr == `A_STAT && wdata[3])
        ferr_r <= 1'b0;
      if (reset_req)
        brk_r <= 1'b1;
      else if (wr && addr == `A_STAT && wdata[4])
        brk_r <= 1'b0;
      if (term_seen)
        term_r <= 1'b1;
      else if (wr && addr == `A_STAT && wdata[5])
        term_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Line input synchronisers and oversampling tick
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_r  <= 3'b111;
      s2_r  <= 3'b111;
      s3_r  <= 3'b111;
      flt_r <= 3'b111;
    end
    else
    begin
      s1_r <= {dsr_n, cts_n, rxd};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 3; i++)
        if (s2_r[i] == s3_r[i])
          flt_r[i] <= s3_r[i];
    end
  end

  // A divisor written below the running count ends the period at once,
  // instead of leaving the tick stalled until the counter wraps.
  assign tick = tcnt_r >= div_r - 16'h0001;

  always_ff @(posedge ref_clk)
  begin
    if (rst || tick)
      tcnt_r <= 16'h0000;
    else
      tcnt_r <= tcnt_r + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Flow control
  // ----------------------------------------------------------------
  // Mixed CTS/DSR levels keep the last decision, giving hysteresis.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hw_clear_r <= 1'b0;
    else if (flt_r[2:1] == 2'b00)
      hw_clear_r <= 1'b1;
    else if (flt_r[2:1] == 2'b11)
      hw_clear_r <= 1'b0;
  end

  assign rts_n = !en;
  assign dtr_n = !en || rx_full_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst || hw)
      pause_r <= 1'b0;
    else if (rx_done && rx_sh_r == `CH_XOFF)
      pause_r <= 1'b1;
    else if (rx_done && rx_sh_r == `CH_XON)
      pause_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xon_pend_r  <= 1'b1;
      xoff_pend_r <= 1'b0;
    end
    else if (hw)
    begin
      xon_pend_r  <= 1'b0;
      xoff_pend_r <= 1'b0;
    end
    else
    begin
      if (rx_done && !rx_full_r && rx_sh_r != `CH_XON && rx_sh_r != `CH_XOFF)
        xoff_pend_r <= 1'b1;
      else if (tx_go && tx_flow && xoff_pend_r)
        xoff_pend_r <= 1'b0;
      if (rx_take && rx_full_r)
        xon_pend_r <= 1'b1;
      else if (tx_go && tx_flow && !xoff_pend_r)
        xon_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Flow characters bypass the pause so the controller is never left
  // waiting for an XON the port cannot send.
  assign tx_flow = sw && (xoff_pend_r || xon_pend_r);
  assign tx_go   = en && tx_st_r == ST_IDLE &&
                   (tx_flow || (txq_v_r && (hw ? hw_clear_r : !pause_r)));
  assign tx_end  = tick && tx_ph_r == 4'hF;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      txq_v_r <= 1'b0;
    else if (wr && addr == `A_TXD && !txq_v_r)
      txq_v_r <= 1'b1;
    else if (tx_go && !tx_flow)
      txq_v_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (wr && addr == `A_TXD && !txq_v_r)
      txq_r <= wdata[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_st_r  <= ST_IDLE;
      tx_ph_r  <= 4'h0;
      tx_bit_r <= 3'd0;
      tx_sh_r  <= 8'hFF;
      tx_par_r <= 1'b0;
    end
    else
    begin
      if (tick && tx_st_r != ST_IDLE)
        tx_ph_r <= tx_ph_r + 4'h1;
      unique case (tx_st_r)
        ST_IDLE:
          if (tx_go)
          begin
            tx_st_r  <= ST_START;
            tx_ph_r  <= 4'h0;
            tx_sh_r  <= !tx_flow ? txq_r : xoff_pend_r ? `CH_XOFF : `CH_XON;
            tx_par_r <= podd;
          end
        ST_START:
          if (tx_end)
          begin
            tx_st_r  <= ST_DATA;
            tx_bit_r <= 3'd0;
          end
        ST_DATA:
          if (tx_end)
          begin
            tx_sh_r  <= {1'b1, tx_sh_r[7:1]};
            tx_par_r <= tx_par_r ^ tx_sh_r[0];
            tx_bit_r <= tx_bit_r + 3'd1;
            if (tx_bit_r == nb)
            begin
              tx_st_r  <= pen ? ST_PAR : ST_STOP;
              tx_bit_r <= 3'd0;
            end
          end
        ST_PAR:
          if (tx_end)
            tx_st_r <= ST_STOP;
        ST_STOP:
          if (tx_end)
          begin
            tx_bit_r <= tx_bit_r + 3'd1;
            if (data8 || tx_bit_r == 3'd1)
              tx_st_r <= ST_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      txd_r <= 1'b1;
    else
      txd_r <= tx_st_r == ST_START ? 1'b0 :
               tx_st_r == ST_DATA  ? tx_sh_r[0] :
               tx_st_r == ST_PAR   ? tx_par_r : 1'b1;
  end

  assign txd = txd_r;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_end   = tick && rx_ph_r == 4'hF;
  assign rx_done  = rx_st_r == ST_STOP && rx_end;
  assign perr_evt = rx_st_r == ST_PAR && rx_end && (rxf != rx_par_r);
  assign ferr_evt = rx_done && !rxf;

  always_ff @(posedge ref_clk)
  begin
    if (rst || !en)
    begin
      rx_st_r  <= ST_IDLE;
      rx_ph_r  <= 4'h0;
      rx_bit_r <= 3'd0;
      rx_sh_r  <= 8'h00;
      rx_par_r <= 1'b0;
    end
    else
    begin
      if (tick && rx_st_r != ST_IDLE)
        rx_ph_r <= rx_ph_r + 4'h1;
      unique case (rx_st_r)
        ST_IDLE:
          if (!rxf && brk_cnt_r == 8'd0)
          begin
            rx_st_r  <= ST_START;
            rx_ph_r  <= 4'h0;
            rx_sh_r  <= 8'h00;
            rx_par_r <= podd;
          end
        ST_START:
          if (tick && rx_ph_r == 4'h7)
          begin
            rx_st_r  <= rxf ? ST_IDLE : ST_DATA;
            rx_ph_r  <= 4'h0;
            rx_bit_r <= 3'd0;
          end
        ST_DATA:
          if (rx_end)
          begin
            rx_sh_r[rx_bit_r] <= rxf;
            rx_par_r <= rx_par_r ^ rxf;
            rx_bit_r <= rx_bit_r + 3'd1;
            if (rx_bit_r == nb)
              rx_st_r <= pen ? ST_PAR : ST_STOP;
          end
        ST_PAR:
          if (rx_end)
            rx_st_r <= ST_STOP;
        ST_STOP:
          if (rx_end)
            rx_st_r <= ST_IDLE;
      endcase
    end
  end

  // A byte that arrives while the buffer is still full is dropped.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_full_r <= 1'b0;
      rx_dat_r  <= 8'h00;
    end
    else if (rx_done && !rx_full_r && !(sw && (rx_sh_r == `CH_XON ||
             rx_sh_r == `CH_XOFF)))
    begin
      rx_full_r <= 1'b1;
      rx_dat_r  <= rx_sh_r;
    end
    else if (rx_take)
      rx_full_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      term_seen <= 1'b0;
    else
      term_seen <= rx_done && (rx_sh_r == `CH_CR || rx_sh_r == `CH_LF);
  end

  // Break: the line stays low for a whole frame, start to last stop.
  assign brk_lim = pen ? `BRK_TICKS_PAR : `BRK_TICKS;

  always_ff @(posedge ref_clk)
  begin
    if (rst || rxf || !en)
      brk_cnt_r <= 8'd0;
    else if (tick && brk_cnt_r != 8'hFF)
      brk_cnt_r <= brk_cnt_r + 8'd1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reset_req <= 1'b0;
    else
      reset_req <= tick && brk_cnt_r == brk_lim - 8'd1;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_div_default: assert property (@(posedge ref_clk)
    rst && !gpib_mode |=> div_r == 16'(`DIV_DEF))
    else $error("divisor not at default rate after reset");
  a_div_bus: assert property (@(posedge ref_clk)
    rst && gpib_mode |=> div_r == 16'(`DIV_BUS))
    else $error("divisor not at bus rate after reset");
  a_start_low: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(tx_st_r == ST_START) |=> !txd [*8])
    else $error("start bit not low");
  a_rts_active: assert property (@(posedge ref_clk) disable iff (rst)
    en |-> !rts_n)
    else $error("rts not active while enabled");
  a_dtr_ready: assert property (@(posedge ref_clk) disable iff (rst)
    en && rx_take && !rx_done |=> !dtr_n)
    else $error("dtr not ready after buffer read");
  a_xoff_full: assert property (@(posedge ref_clk) disable iff (rst)
    sw && $rose(rx_full_r) |-> xoff_pend_r || $past(tx_go))
    else $error("xoff not queued on full buffer");
  a_hw_hold: assert property (@(posedge ref_clk) disable iff (rst)
    hw && !hw_clear_r && tx_st_r == ST_IDLE |=> tx_st_r == ST_IDLE)
    else $error("transmit started without cts and dsr");
  a_pause_hold: assert property (@(posedge ref_clk) disable iff (rst)
    sw && pause_r && !tx_flow && tx_st_r == ST_IDLE |=> tx_st_r == ST_IDLE)
    else $error("transmit started while paused");
  a_false_start: assert property (@(posedge ref_clk) disable iff (rst)
    en && rx_st_r == ST_START && tick && rx_ph_r == 4'h7 && rxf
    |=> rx_st_r == ST_IDLE)
    else $error("glitch accepted as start bit");
  a_break_low: assert property (@(posedge ref_clk) disable iff (rst)
    reset_req |-> !rxf && $past(brk_cnt_r) == brk_lim - 8'd1)
    else $error("reset request without break");
endmodule

// [verification/remote_host_model.sv]
`timescale 1ns/1ps
module remote_host_model #(
  parameter int BIT_CYC = 64
) (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n,
  output logic      dsr_n
);
  // ----------------------------------------
  // Controller side of the null-modem link
  // ----------------------------------------
  // BIT_CYC must be 16 times the divisor the bench programs, or every frame is garbled.
  initial
  begin
    rxd   = 1'b1;
    cts_n = 1'b0;
    dsr_n = 1'b0;
  end

  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk) rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk) rxd <= 1'b1;
  endtask

  task automatic pulse(input int n);
    @(posedge ref_clk) rxd <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rxd <= 1'b1;
  endtask

  task automatic hold_ready(input logic v);
    @(posedge ref_clk);
    cts_n <= v;
    dsr_n <= v;
  endtask

  task automatic grab(input int n, output logic [11:0] f, output logic ok);
    int w;
    f = '1;
    w = 0;
    while (txd !== 1'b0 && w < 5000)
    begin
      @(posedge ref_clk);
      w++;
    end
    ok = (txd === 1'b0);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask
endmodule

// [verification/rs232_uart_flow_control_tb.sv]
`timescale 1ns/1ps
`include "uart_consts.svh"
module rs232_uart_flow_control_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        gpib_mode = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [11:0] f;
  logic        rxd, txd, cts_n, dsr_n, dtr_n, rts_n, reset_req, term_seen;
  logic [5:0]  cfgs [6] = '{6'h31, 6'h33, 6'h35, 6'h30, 6'h32, 6'h34};
  int          failures, num_checks, n_brk, n_term, n;

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    if (reset_req === 1'b1) n_brk++;
    if (term_seen === 1'b1) n_term++;
  end

  rs232_uart_flow_control dut (.ref_clk(ref_clk), .rst(rst), .gpib_mode(gpib_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
    .cts_n(cts_n), .dsr_n(dsr_n), .dtr_n(dtr_n), .rts_n(rts_n), .reset_req(reset_req),
    .term_seen(term_seen));

  remote_host_model #(.BIT_CYC(64)) ph (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
    .cts_n(cts_n), .dsr_n(dsr_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask

  // Builds the expected wire pattern, start bit in bit 0, idle ones above the frame.
  function automatic logic [11:0] mk(input logic [7:0] b, input logic [5:0] c, output int nb);
    int k;
    mk = '1;
    mk[0] = 1'b0;
    mk[8:1] = b & (c[0] ? 8'hFF : 8'h7F);
    k = c[0] ? 9 : 8;
    mk[k] = 1'b1;
    if (c[2:1] != 2'b00)
    begin
      mk[k] = ^(b & (c[0] ? 8'hFF : 8'h7F)) ^ c[2];
      k++;
    end
    nb = k + (c[0] ? 1 : 2);
  endfunction

  task automatic tx_chk(input logic [7:0] b, input logic [5:0] c);
    logic [11:0] e, g;
    logic        ok;
    int          nb;
    e = mk(b, c, nb);
    ph.grab(nb, g, ok);
    chk(ok, 1'b1);
    chk(g, e);
  endtask

  task automatic rx(input logic [7:0] b, input logic [5:0] c);
    logic [11:0] e;
    int          nb;
    e = mk(b, c, nb);
    ph.send(e, nb);
  endtask

  task automatic quiet;
    logic s;
    s = 1'b0;
    repeat (300)
    begin
      @(negedge ref_clk);
      if (txd !== 1'b1) s = 1'b1;
    end
    chk(s, 1'b0);
  endtask

  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(`A_DIV, d);
    chk(d, `DIV_BUS);
    @(posedge ref_clk);
    rst <= 1'b1;
    gpib_mode <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(`A_DIV, d);
    chk(d, `DIV_DEF);
    rd_reg(`A_CFG, d);
    chk(d, 32'h0000_0001);
    chk(rts_n, 1'b1);
    rd_reg(8'h14, d);
    chk(d, 32'h0000_0000);
    wr_reg(`A_DIV, 32'h0000_0036);
    wr_reg(`A_DIV, 32'h0000_0000);
    rd_reg(`A_DIV, d);
    chk(d, 32'h0000_0036);
    wr_reg(`A_DIV, 32'h0000_0004);
    fork
      wr_reg(`A_CFG, 32'h0000_0021);
      tx_chk(`CH_XON, 6'h21);
    join
    chk(rts_n, 1'b0);
    rx(`CH_XOFF, 6'h21);
    wr_reg(`A_TXD, 32'h0000_0033);
    wr_reg(`A_TXD, 32'h0000_0077);
    quiet();
    rd_reg(`A_STAT, d);
    chk(d[7:0], 8'hC2);
    fork
      rx(`CH_XON, 6'h21);
      tx_chk(8'h33, 6'h21);
    join
    rd_reg(`A_STAT, d);
    chk(d[0], 1'b0);
    // The host sends nothing more after this XOFF until the XON below.
    fork
      rx(`CH_CR, 6'h21);
      tx_chk(`CH_XOFF, 6'h21);
    join
    chk(n_term, 1);
    rd_reg(`A_STAT, d);
    chk(d[5:0], 6'h21);
    fork
      rd_reg(`A_RXD, d);
      tx_chk(`CH_XON, 6'h21);
    join
    chk(d, `CH_CR);
    wr_reg(`A_STAT, 32'h0000_003C);
    rd_reg(`A_STAT, d);
    chk(d[7:0], 8'h40);
    foreach (cfgs[i])
    begin
      wr_reg(`A_CFG, {26'd0, cfgs[i]});
      fork
        wr_reg(`A_TXD, 32'h0000_00C5);
        tx_chk(8'hC5, cfgs[i]);
      join
      rx(8'hA6, cfgs[i]);
      chk(dtr_n, 1'b1);
      chk(rts_n, 1'b0);
      rd_reg(`A_RXD, d);
      chk(d, cfgs[i][0] ? 32'h0000_00A6 : 32'h0000_0026);
      chk(dtr_n, 1'b0);
      rd_reg(`A_STAT, d);
      chk(d[3:2], 2'b00);
    end
    ph.pulse(16);
    repeat (800) @(posedge ref_clk);
    rd_reg(`A_STAT, d);
    chk(d[3:0], 4'h0);
    wr_reg(`A_CFG, 32'h0000_0031);
    ph.hold_ready(1'b1);
    repeat (8) @(posedge ref_clk);
    wr_reg(`A_TXD, 32'h0000_005A);
    quiet();
    fork
      ph.hold_ready(1'b0);
      tx_chk(8'h5A, 6'h31);
    join
    wr_reg(`A_CFG, 32'h0000_0033);
    f = mk(8'h41, 6'h33, n);
    f[9] = ~f[9];
    ph.send(f, n);
    rd_reg(`A_STAT, d);
    chk(d[2], 1'b1);
    rd_reg(`A_RXD, d);
    wr_reg(`A_STAT, 32'h0000_003C);
    wr_reg(`A_CFG, 32'h0000_0031);
    f = mk(8'h41, 6'h31, n);
    f[9] = 1'b0;
    ph.send(f, n);
    rd_reg(`A_STAT, d);
    chk(d[3], 1'b1);
    rd_reg(`A_RXD, d);
    ph.send(12'h000, 12);
    chk(n_brk, 1);
    rd_reg(`A_STAT, d);
    chk(d[4], 1'b1);
    end_sim();
  end
endmodule
